//--- verilog/tpc_cfg.svh
// tpc_cfg.svh: addresses, field positions, reset values and timing counts
// assumes: included by the touch pacing control package and modules only
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

`define TPC_ADDR_W 4
`define TPC_DATA_W 16
`define TPC_ADDR_TIMING 4'hC
`define TPC_ADDR_PACING 4'hD
`define TPC_LONG_SAMPLE_BIT 0
`define TPC_WAIT_DETECT_BIT 1
`define TPC_BATCH_SEL_LSB 0
`define TPC_BATCH_SEL_W 3
`define TPC_TIMING_RESET 2'h0
`define TPC_PACING_RESET 3'h0
`define TPC_SEL_NONE 3'h0
`define TPC_SEL_1000 3'h1
`define TPC_SEL_500 3'h2

`define TPC_CLK_MHZ 40
`define TPC_LONG_SAMPLE_NS 500
// least time: round up to whole cycles
`define TPC_LONG_SAMPLE_CYC ((`TPC_LONG_SAMPLE_NS * `TPC_CLK_MHZ + 999) / 1000)
`define TPC_BATCH_1000_US 1000
`define TPC_BATCH_500_US 2000
`define TPC_BATCH_1000_CYC (`TPC_BATCH_1000_US * `TPC_CLK_MHZ)
`define TPC_BATCH_500_CYC (`TPC_BATCH_500_US * `TPC_CLK_MHZ)
`define TPC_SAMPLE_BASE_CYC 4

`endif

//--- verilog/tpc_pkg.sv
// tpc_pkg: state types of the touch pacing control block
// assumes: tpc_cfg.svh on the include path
`include "tpc_cfg.svh"

package tpc_pkg;

	typedef enum logic [2:0] {
		TPC_IDLE = 3'h1,
		TPC_RUN = 3'h2,
		TPC_WAIT = 3'h4
	} tpc_batch_state_t;

	typedef struct packed {
		logic wait_detect_en;
		logic long_sample_en;
		logic [`TPC_BATCH_SEL_W-1:0] batch_sel;
		logic [`TPC_DATA_W-1:0] rdata;
		logic pin;
		logic sample_busy;
		tpc_batch_state_t batch;
		logic set_go;
		logic scan_stop;
	} tpc_state_t;

endpackage : tpc_pkg

//--- verilog/tpc_down_cnt.sv
// tpc_down_cnt: loadable down counter, holds at zero
// assumes: single clock, clock enable freezes it
`timescale 1ns/1ps
`default_nettype none

module tpc_down_cnt #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic load_i,
	input wire logic [W-1:0] load_val_i,
	output logic zero_o
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;

	always_comb begin
		next_count = count;
		if (load_i) begin
			next_count = load_val_i;
		end else if (count != '0) begin
			next_count = count - W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= '0;
		end else if (ce_i) begin
			count <= next_count;
		end
	end

	assign zero_o = (count == '0);

endmodule : tpc_down_cnt

`default_nettype wire

//--- verilog/tpc_ctrl.sv
// tpc_ctrl: configuration, wait detection, sample stretch and batch pacing
// assumes: register port driven by the serial transport, sequencer strobes synchronous
//
// Contract
// - Wait-detect enable keeps touch sensing alive while waiting for convert.
// - During wait detection, pin driven high when no touch is seen.
// - Long-sample bit adds 500 ns to every sampling phase.
// - Wait-detect enable is timing register bit 1, read/write, resets 0.
// - Long-sample enable is timing register bit 0, read/write, resets 0.
// - Pacing register at Dh resets zero; selector in bits 2-0.
// - Selector 0 unpaced, 1 gives 1000 sets/s, 2 gives 500 sets/s.
// - After a set, idle until delay ends; continue only if touch persists.
// - If a set outlasts the delay, the set itself sets the pace.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_cfg.svh"

module tpc_ctrl
	import tpc_pkg::*;
#(
	parameter int SAMPLE_BASE_CYC = `TPC_SAMPLE_BASE_CYC,
	parameter int BATCH_1000_CYC = `TPC_BATCH_1000_CYC,
	parameter int BATCH_500_CYC = `TPC_BATCH_500_CYC,
	parameter int BATCH_W = 17,
	parameter int SAMPLE_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [`TPC_ADDR_W-1:0] reg_addr_i,
	input wire logic [`TPC_DATA_W-1:0] reg_wdata_i,
	output logic [`TPC_DATA_W-1:0] reg_rdata_o,
	input wire logic pen_touch_i,
	input wire logic host_wait_i,
	input wire logic pin_level_i,
	output logic pen_irq_data_avail_pin_o,
	input wire logic sample_start_i,
	output logic sample_busy_o,
	input wire logic set_start_i,
	input wire logic set_done_i,
	output logic set_go_o,
	output logic scan_stop_o,
	output logic batch_wait_o
);
	tpc_state_t s;
	tpc_state_t next_s;
	logic sample_zero;
	logic batch_zero;
	logic [SAMPLE_W-1:0] sample_len;
	logic [BATCH_W-1:0] batch_len;
	logic paced;

	// stretch length picked at the start strobe; a later bit change waits for the next sample
	// busy spans the count down to zero inclusive, so the load is one short
	always_comb begin
		sample_len = SAMPLE_W'(SAMPLE_BASE_CYC - 1);
		if (s.long_sample_en) begin
			sample_len = SAMPLE_W'(SAMPLE_BASE_CYC + `TPC_LONG_SAMPLE_CYC - 1);
		end
		case (s.batch_sel)
			`TPC_SEL_1000: batch_len = BATCH_W'(BATCH_1000_CYC);
			`TPC_SEL_500: batch_len = BATCH_W'(BATCH_500_CYC);
			default: batch_len = '0;
		endcase
	end

	// unlisted selector codes fall back to unpaced operation
	assign paced = (batch_len != '0);

	tpc_down_cnt #(.W(SAMPLE_W)) u_sample_cnt (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.load_i(sample_start_i),
		.load_val_i(sample_len),
		.zero_o(sample_zero)
	);

	// delay runs from the start of a set, so a long set eats into it
	tpc_down_cnt #(.W(BATCH_W)) u_batch_cnt (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.load_i(set_start_i),
		.load_val_i(batch_len),
		.zero_o(batch_zero)
	);

	always_comb begin
		next_s = s;
		next_s.set_go = 1'b0;
		next_s.scan_stop = 1'b0;
		if (reg_wr_i && reg_addr_i == `TPC_ADDR_TIMING) begin
			next_s.wait_detect_en = reg_wdata_i[`TPC_WAIT_DETECT_BIT];
			next_s.long_sample_en = reg_wdata_i[`TPC_LONG_SAMPLE_BIT];
		end
		if (reg_wr_i && reg_addr_i == `TPC_ADDR_PACING) begin
			next_s.batch_sel = reg_wdata_i[`TPC_BATCH_SEL_LSB +: `TPC_BATCH_SEL_W];
		end
		if (reg_rd_i) begin
			next_s.rdata = '0;
			if (reg_addr_i == `TPC_ADDR_TIMING) begin
				next_s.rdata[`TPC_WAIT_DETECT_BIT] = s.wait_detect_en;
				next_s.rdata[`TPC_LONG_SAMPLE_BIT] = s.long_sample_en;
			end else if (reg_addr_i == `TPC_ADDR_PACING) begin
				next_s.rdata[`TPC_BATCH_SEL_LSB +: `TPC_BATCH_SEL_W] = s.batch_sel;
			end
		end
		// background sensing only matters while the host owes a convert
		if (s.wait_detect_en && host_wait_i) begin
			next_s.pin = !pen_touch_i;
		end else begin
			next_s.pin = pin_level_i;
		end
		if (sample_start_i) begin
			next_s.sample_busy = 1'b1;
		end else if (s.sample_busy && sample_zero) begin
			next_s.sample_busy = 1'b0;
		end
		case (s.batch)
			TPC_IDLE: begin
				if (set_start_i) begin
					next_s.batch = TPC_RUN;
				end
			end
			TPC_RUN: begin
				if (set_done_i) begin
					if (paced && !batch_zero) begin
						next_s.batch = TPC_WAIT;
					end else begin
						// set outlasted the delay or no delay: go at once if touch persists, else stop scan
						next_s.set_go = pen_touch_i;
						next_s.scan_stop = !pen_touch_i;
						next_s.batch = TPC_IDLE;
					end
				end
			end
			TPC_WAIT: begin
				if (batch_zero) begin
					next_s.set_go = pen_touch_i;
					next_s.scan_stop = !pen_touch_i;
					next_s.batch = TPC_IDLE;
				end
			end
			default: begin
				next_s.batch = TPC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s.wait_detect_en <= 1'(`TPC_TIMING_RESET >> `TPC_WAIT_DETECT_BIT);
			s.long_sample_en <= 1'(`TPC_TIMING_RESET >> `TPC_LONG_SAMPLE_BIT);
			s.batch_sel <= `TPC_PACING_RESET;
			s.rdata <= '0;
			s.pin <= 1'b0;
			s.sample_busy <= 1'b0;
			s.batch <= TPC_IDLE;
			s.set_go <= 1'b0;
			s.scan_stop <= 1'b0;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	assign reg_rdata_o = s.rdata;
	assign pen_irq_data_avail_pin_o = s.pin;
	assign sample_busy_o = s.sample_busy;
	assign set_go_o = s.set_go;
	assign scan_stop_o = s.scan_stop;
	assign batch_wait_o = (s.batch == TPC_WAIT);

	default clocking cb @(posedge clk_i iff ce_i); endclocking
	default disable iff (!rst_n_i);

	sequence seq_wait_idle;
		s.wait_detect_en && host_wait_i && !pen_touch_i;
	endsequence

	sequence seq_wait_lost;
		s.batch == TPC_WAIT && batch_zero && !pen_touch_i;
	endsequence

	a_wait_pin_high: assert property (seq_wait_idle |=> pen_irq_data_avail_pin_o)
		else $error("pin not high during idle wait detection");
	a_wait_pin_touch: assert property (s.wait_detect_en && host_wait_i && pen_touch_i
		|=> !pen_irq_data_avail_pin_o)
		else $error("touch not seen during wait detection");
	a_long_sample_len: assert property (sample_start_i && s.long_sample_en
		|=> sample_busy_o [*8])
		else $error("long sample phase too short");
	a_timing_write: assert property (reg_wr_i && reg_addr_i == `TPC_ADDR_TIMING
		|=> s.wait_detect_en == $past(reg_wdata_i[1]))
		else $error("wait detect bit not stored");
	a_timing_lsb: assert property (reg_wr_i && reg_addr_i == `TPC_ADDR_TIMING
		|=> s.long_sample_en == $past(reg_wdata_i[0]))
		else $error("long sample bit not stored");
	a_pacing_read: assert property (reg_rd_i && reg_addr_i == `TPC_ADDR_PACING
		|=> reg_rdata_o == {13'h0000, $past(s.batch_sel)})
		else $error("pacing readback wrong");
	a_reserved_zero: assert property (reg_rd_i |=> reg_rdata_o[15:3] == 13'h0000)
		else $error("reserved bits not zero");
	a_unpaced_go: assert property (s.batch == TPC_RUN && set_done_i && !paced && pen_touch_i
		|=> set_go_o)
		else $error("unpaced set not released");
	a_wait_hold: assert property (s.batch == TPC_WAIT && !batch_zero
		|=> !set_go_o && !scan_stop_o)
		else $error("set released before delay end");
	a_late_set_go: assert property (s.batch == TPC_RUN && set_done_i && batch_zero
		|=> (set_go_o || scan_stop_o) && !batch_wait_o)
		else $error("late set stalled by delay");
	a_wait_enter: assert property (s.batch == TPC_RUN && set_done_i && paced && !batch_zero
		|=> batch_wait_o)
		else $error("paced set did not idle");
	a_wait_stop: assert property (seq_wait_lost |=> scan_stop_o && !set_go_o)
		else $error("scan not stopped after lost touch");
	a_busy_start: assert property (sample_start_i |=> sample_busy_o)
		else $error("sampling phase not started");

endmodule : tpc_ctrl

`default_nettype wire

//--- dv/tpc_host_model.sv
// tpc_host_model: host that polls the pen/data pin before sending a convert
// assumes: pin is a registered level from the block, same clock
`timescale 1ns/1ps
`default_nettype none

module tpc_host_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic pin_i,
	input wire logic want_i,
	output logic host_wait_o
);
	logic sent;
	logic armed;

	// convert withheld while pin high; once sent, no new wait until want drops
	// pin is registered and lags the wait by one edge, so it is ignored until armed
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			host_wait_o <= 1'b0;
			sent <= 1'b0;
			armed <= 1'b0;
		end else begin
			host_wait_o <= want_i & !sent & !(host_wait_o & armed & !pin_i);
			sent <= want_i & (sent | (host_wait_o & armed & !pin_i));
			armed <= host_wait_o;
		end
	end
endmodule : tpc_host_model
`default_nettype wire

//--- dv/tpc_ctrl_tb.sv
// tpc_ctrl_tb: self-checking bench for the touch pacing control block
// assumes: host model in dv/, pacing counts shortened to 40 and 80
`timescale 1ns/1ps
`default_nettype none
`include "tpc_cfg.svh"

module tpc_ctrl_tb;
	import tpc_pkg::*;
	logic clk_i = 0, rst_n_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0, rd_seen = 0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, exp_q[$];
	logic pen_touch_i = 0, want = 0, pin_level_i = 0, sample_start_i = 0, set_start_i = 0;
	logic set_done_i = 0, host_wait_i, pin_o, busy, go, stop, bwait;
	int mismatches = 0, checks = 0;

	always #12.5 clk_i = ~clk_i;

	tpc_ctrl #(.BATCH_1000_CYC(40), .BATCH_500_CYC(80)) u_dut (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.pen_touch_i(pen_touch_i), .host_wait_i(host_wait_i), .pin_level_i(pin_level_i),
		.pen_irq_data_avail_pin_o(pin_o), .sample_start_i(sample_start_i),
		.sample_busy_o(busy), .set_start_i(set_start_i), .set_done_i(set_done_i),
		.set_go_o(go), .scan_stop_o(stop), .batch_wait_o(bwait));
	tpc_host_model u_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .pin_i(pin_o),
		.want_i(want), .host_wait_o(host_wait_i));

	task report_and_stop;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc

	task wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1;
		cyc(1);
		reg_wr_i = 0;
	endtask : wr

	task rd(input logic [3:0] a, input logic [15:0] e);
		reg_addr_i = a;
		reg_rd_i = 1;
		exp_q.push_back(e);
		cyc(1);
		reg_rd_i = 0;
	endtask : rd

	// read data settles one edge after the strobe
	always @(posedge clk_i) rd_seen <= reg_rd_i;
	always @(negedge clk_i) if (rd_seen) chk("rdata", reg_rdata_o, exp_q.pop_front());

	task samp(input logic lng, input int len);
		int n;
		wr(`TPC_ADDR_TIMING, {15'h0000, lng});
		sample_start_i = 1;
		cyc(1);
		sample_start_i = 0;
		n = 0;
		while (busy === 1'b1 && n < 100) begin
			n++;
			cyc(1);
		end
		chk("busy len", 16'(n), 16'(len));
	endtask : samp

	task batch(input logic [2:0] sel, input int gap, input logic t, input int lo, input int hi);
		int n;
		wr(`TPC_ADDR_PACING, {13'h0000, sel});
		pen_touch_i = t;
		set_start_i = 1;
		cyc(1);
		set_start_i = 0;
		cyc(gap);
		set_done_i = 1;
		cyc(1);
		set_done_i = 0;
		chk("idle", 16'(bwait), 16'(lo > 1));
		n = 0;
		while (!(go === 1'b1 || stop === 1'b1) && n < 200) begin
			cyc(1);
			n++;
		end
		chk("pace", 16'(n >= lo && n <= hi), 16'h0001);
		chk("go", 16'(go), 16'(t));
		chk("stop", 16'(stop), 16'(!t));
	endtask : batch

	initial begin
		logic [15:0] r;
		r = 16'($urandom(65));
		cyc(8);
		rst_n_i = 1;
		cyc(1);
		rd(`TPC_ADDR_TIMING, 16'h0000);
		cyc(1);
		rd(`TPC_ADDR_PACING, 16'h0000);
		repeat (4) begin
			r = 16'($urandom);
			wr(`TPC_ADDR_PACING, r);
			rd(`TPC_ADDR_PACING, {13'h0000, r[2:0]});
			wr(`TPC_ADDR_TIMING, r);
			rd(`TPC_ADDR_TIMING, {14'h0000, r[1:0]});
		end
		wr(4'h3, 16'hFFFF);
		rd(4'h3, 16'h0000);
		wr(`TPC_ADDR_TIMING, 16'h0002);
		want = 1;
		cyc(10);
		chk("pin idle", 16'(pin_o), 16'h0001);
		pen_touch_i = 1;
		cyc(2);
		chk("pin touch", 16'(pin_o), 16'h0000);
		want = 0;
		pen_touch_i = 0;
		wr(`TPC_ADDR_TIMING, 16'h0000);
		want = 1;
		cyc(10);
		chk("pin off", 16'(pin_o), 16'h0000);
		want = 0;
		pin_level_i = 1;
		cyc(2);
		chk("pin level", 16'(pin_o), 16'h0001);
		samp(0, `TPC_SAMPLE_BASE_CYC);
		samp(1, `TPC_SAMPLE_BASE_CYC + `TPC_LONG_SAMPLE_CYC);
		batch(3'h0, 3, 1, 0, 0);
		batch(3'h1, 3, 1, 32, 40);
		batch(3'h2, 3, 1, 72, 80);
		batch(3'h1, 3, 0, 32, 40);
		batch(3'h1, 50, 1, 0, 0);
		// frozen clock enable must drop the write
		ce_i = 0;
		wr(`TPC_ADDR_PACING, 16'h0002);
		ce_i = 1;
		rd(`TPC_ADDR_PACING, 16'h0001);
		cyc(2);
		report_and_stop();
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		report_and_stop();
	end
endmodule : tpc_ctrl_tb
`default_nettype wire
